// ---- cvdsq_pkg.sv ----
// Purpose: shared constants for the cvd acquisition sequencer
// Assumes: 32-bit ahb-lite register bus, word per register
// Notes: printed offsets are not word multiples, so they are indices
package cvdsq_pkg;
  // register indices, byte address is four times the index
  localparam logic [15:0] IDX_CTRL0 = 16'h1D26; // converter_control_zero
  localparam logic [15:0] IDX_CVDCTL = 16'h1D27; // cvd_control
  localparam logic [15:0] IDX_PRE = 16'h1D40; // precharge_time_reg
  localparam logic [15:0] IDX_ACQ = 16'h1D41; // acquisition_time_reg
  localparam logic [15:0] IDX_CAP = 16'h1D42; // extra_hold_cap_select
  localparam logic [15:0] IDX_CLKDIV = 16'h1D43; // clock_divider_reg
  localparam logic [15:0] IDX_RES = 16'h1D44; // result_reg
  localparam logic [15:0] IDX_PREV = 16'h1D45; // previous_result_reg
  localparam logic [15:0] IDX_STAT = 16'h1D46; // status flags
  // control zero fields
  localparam int B_ON = 7;
  localparam int B_CONTINUOUS_EN = 6;
  localparam int B_CS = 4;
  localparam int B_FM = 2;
  localparam int B_GO = 0;
  // cvd control fields
  localparam int B_PRECHARGE_POLARITY = 7;
  localparam int B_INVERT_PRECHARGE_EN = 6;
  localparam int B_GUARD_POLARITY = 5;
  localparam int B_PRECHARGE_INTERNAL_ONLY = 1;
  localparam int B_DOUBLE_SAMPLE_EN = 0;
  // status fields
  localparam int B_CIF = 0;
  localparam int B_TIF = 1;
  localparam int B_SOI = 2;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  // conversion length in conversion clock periods
  localparam logic [3:0] CONV_TICKS = 4'hB;
  // sequencer states
  typedef enum logic [1:0] {
    CVDSQ_IDLE = 2'b00,
    CVDSQ_PRE = 2'b01,
    CVDSQ_ACQ = 2'b10,
    CVDSQ_CONV = 2'b11
  } cvdsq_state_t;
endpackage

// ---- cvdsq_top.sv ----
// Purpose: precharge/acquisition sequencer with guard ring drive
// Assumes: one clock hclk, ahb-lite slave, analog switches outside
// Notes: converter core stubbed by a fixed-length count and sample input
// Notes on behaviour
// - acquisition follows precharge, timed by register
// - acquisition releases pin drive, connects hold cap
// - precharge on: acquisition zero means maximum
// - precharge off: acquisition zero disables timing
// - two guard outputs, polarity from one bit
// - first precharge drives guards to polarity bit
// - acquisition inverts guard a, keeps b
// - inverted second precharge flips guards, a toggles
// - extra capacitance only while sampling
// - control zero bit 7 enables converter
// - continuous retriggers start until threshold/software
// - bit 4 picks rc oscillator or divider
// - bit 2 right justifies result registers
// - start bit begins cycle, reads busy
// - software abort keeps partial result, no flag
// - precharge polarity sets pin and hold levels
// - inverted precharge flips second cycle polarities
// - guard polarity bit sets starting guard level
// - internal-only bit keeps pin undriven in precharge
// - double sample pairs conversions, computes every second
// - zero precharge time skips precharge
`timescale 1ns/10ps
`default_nettype none
module cvdsq_top #(
  parameter int RES_W = 10 // converter result width
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // converter side
  input wire logic rc_osc_tick, // one-cycle pulse from dedicated oscillator
  input wire logic [RES_W-1:0] sample_data, // converter core value
  input wire logic threshold_hit, // computation reports threshold met
  // analog controls
  output logic pin_drive_en, // override of channel pin drivers
  output logic pin_drive_level, // level of the override
  output logic hold_to_vdd, // hold capacitor precharged high
  output logic hold_bias_en, // hold capacitor tied to a rail
  output logic hold_connect, // channel connected to hold capacitor
  output logic [7:0] extra_cap_sel, // extra capacitance, zero when off
  output logic guard_out_a,
  output logic guard_out_b,
  output logic compute_pulse // compute after single or pair
);
  // registers
  logic [7:0] ctrl0_q; // go lives in go_q
  logic go_q;
  logic [7:0] cvdctl_q;
  logic [7:0] pre_q, acq_q, cap_q, clkdiv_q;
  logic [15:0] res_q, prev_q;
  logic cif_q, tif_q, soi_q;
  // bus pipeline
  logic wr_pend_q;
  logic [15:0] widx_q;
  cvdsq_pkg::cvdsq_state_t st_q;
  logic [7:0] cnt_q; // stage down-counter
  logic [7:0] div_q; // system clock divider
  logic second_q; // second of a double-sample pair
  logic sw_go_clr, sw_go_set;
  logic tick;
  logic invert_precharge_en_act;
  logic end_conv;

  // only haddr[17:2] is decoded; higher address bits alias
  // map a bus address to a register index
  function automatic logic [15:0] idx_of(input logic [31:0] a);
    idx_of = a[17:2];
  endfunction

  // hwdata trails its address by one cycle, hence the pending flag
  // address phase write is captured, data lands next cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      widx_q <= 16'h0000;
    end else if (hready) begin
      wr_pend_q <= hsel && htrans[1] && hwrite;
      widx_q <= idx_of(haddr);
    end
  end

  // no register needs extra time, so wait states are never inserted
  // zero-wait answers, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // data stands through the data phase, where the master samples it
  // read data registered in address phase; unmapped reads zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      unique case (idx_of(haddr))
        cvdsq_pkg::IDX_CTRL0: hrdata <= {24'h000000, ctrl0_q[7:1], go_q};
        cvdsq_pkg::IDX_CVDCTL: hrdata <= {24'h000000, cvdctl_q};
        cvdsq_pkg::IDX_PRE: hrdata <= {24'h000000, pre_q};
        cvdsq_pkg::IDX_ACQ: hrdata <= {24'h000000, acq_q};
        cvdsq_pkg::IDX_CAP: hrdata <= {24'h000000, cap_q};
        cvdsq_pkg::IDX_CLKDIV: hrdata <= {24'h000000, clkdiv_q};
        cvdsq_pkg::IDX_RES: hrdata <= {16'h0000, res_q};
        cvdsq_pkg::IDX_PREV: hrdata <= {16'h0000, prev_q};
        cvdsq_pkg::IDX_STAT: hrdata <= {29'h00000000, soi_q, tif_q, cif_q};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  // the start bit is kept apart because hardware also clears it
  // plain control registers; reserved bits of control zero held at zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl0_q <= cvdsq_pkg::RST_BYTE;
      cvdctl_q <= cvdsq_pkg::RST_BYTE;
      pre_q <= cvdsq_pkg::RST_BYTE;
      acq_q <= cvdsq_pkg::RST_BYTE;
      cap_q <= cvdsq_pkg::RST_BYTE;
      clkdiv_q <= cvdsq_pkg::RST_BYTE;
      soi_q <= 1'b0;
    end else if (wr_pend_q) begin
      unique case (widx_q)
        cvdsq_pkg::IDX_CTRL0: ctrl0_q <= hwdata[7:0] & 8'hD4;
        cvdsq_pkg::IDX_CVDCTL: cvdctl_q <= hwdata[7:0] & 8'hE3;
        cvdsq_pkg::IDX_PRE: pre_q <= hwdata[7:0];
        cvdsq_pkg::IDX_ACQ: acq_q <= hwdata[7:0];
        cvdsq_pkg::IDX_CAP: cap_q <= hwdata[7:0];
        cvdsq_pkg::IDX_CLKDIV: clkdiv_q <= hwdata[7:0];
        cvdsq_pkg::IDX_STAT: soi_q <= hwdata[cvdsq_pkg::B_SOI];
        default: ;
      endcase
    end
  end

  // a write of control zero with the start bit low is an abort
  // software start and stop strobes
  assign sw_go_set = wr_pend_q && (widx_q == cvdsq_pkg::IDX_CTRL0)
                     && hwdata[cvdsq_pkg::B_GO] && hwdata[cvdsq_pkg::B_ON];
  assign sw_go_clr = wr_pend_q && (widx_q == cvdsq_pkg::IDX_CTRL0)
                     && !hwdata[cvdsq_pkg::B_GO];
  assign invert_precharge_en_act = cvdctl_q[cvdsq_pkg::B_INVERT_PRECHARGE_EN] && cvdctl_q[cvdsq_pkg::B_DOUBLE_SAMPLE_EN];

  // the divider runs free; a new reload takes effect at the next compare
  // rc pulses are taken as already synchronous to hclk
  // conversion clock: rc pulse or divided system clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q <= 8'h00;
    end else if (div_q >= clkdiv_q) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end
  assign tick = ctrl0_q[cvdsq_pkg::B_CS] ? rc_osc_tick : (div_q >= clkdiv_q);

  // last conversion tick; shared by start bit, pair and result logic
  assign end_conv = (st_q == cvdsq_pkg::CVDSQ_CONV) && tick && (cnt_q == 8'h01);

  // disable and abort win over every stage, so the machine restarts clean
  // stage sequencer with down-counter in conversion clock periods
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= cvdsq_pkg::CVDSQ_IDLE;
      cnt_q <= 8'h00;
    end else if (!ctrl0_q[cvdsq_pkg::B_ON] || sw_go_clr) begin
      st_q <= cvdsq_pkg::CVDSQ_IDLE;
    end else begin
      unique case (st_q)
        cvdsq_pkg::CVDSQ_IDLE: if (go_q) begin
          if (pre_q != 8'h00) begin
            st_q <= cvdsq_pkg::CVDSQ_PRE;
            cnt_q <= pre_q;
          end else if (acq_q != 8'h00) begin
            st_q <= cvdsq_pkg::CVDSQ_ACQ;
            cnt_q <= acq_q;
          end else begin
            // no hardware acquisition timing: hold is never switched in
            st_q <= cvdsq_pkg::CVDSQ_CONV;
            cnt_q <= {4'h0, cvdsq_pkg::CONV_TICKS};
          end
        end
        cvdsq_pkg::CVDSQ_PRE: if (tick) begin
          if (cnt_q == 8'h01) begin
            st_q <= cvdsq_pkg::CVDSQ_ACQ;
            cnt_q <= acq_q; // zero wraps to 256 periods
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        cvdsq_pkg::CVDSQ_ACQ: begin
          // zero with no precharge: skip straight to conversion
          if (pre_q == 8'h00 && acq_q == 8'h00) begin
            st_q <= cvdsq_pkg::CVDSQ_CONV;
            cnt_q <= {4'h0, cvdsq_pkg::CONV_TICKS};
          end else if (tick) begin
            if (cnt_q == 8'h01) begin
              st_q <= cvdsq_pkg::CVDSQ_CONV;
              cnt_q <= {4'h0, cvdsq_pkg::CONV_TICKS};
            end else begin
              cnt_q <= cnt_q - 8'h01;
            end
          end
        end
        cvdsq_pkg::CVDSQ_CONV: if (tick) begin
          if (cnt_q == 8'h01) begin
            st_q <= cvdsq_pkg::CVDSQ_IDLE;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
      endcase
    end
  end

  // a software set in the same cycle as a hardware clear is kept
  // start bit: software set, hardware clear per continuous mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      go_q <= 1'b0;
    end else if (sw_go_set) begin
      go_q <= 1'b1;
    end else if (sw_go_clr || !ctrl0_q[cvdsq_pkg::B_ON]) begin
      go_q <= 1'b0;
    end else if (end_conv) begin
      if (!ctrl0_q[cvdsq_pkg::B_CONTINUOUS_EN]) begin
        go_q <= 1'b0;
      end else if (soi_q && threshold_hit && (second_q || !cvdctl_q[cvdsq_pkg::B_DOUBLE_SAMPLE_EN])) begin
        go_q <= 1'b0;
      end
    end
  end

  // cleared whenever pairing is off, so a new pair always starts first
  // pair tracking for double sampling
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      second_q <= 1'b0;
    end else if (!cvdctl_q[cvdsq_pkg::B_DOUBLE_SAMPLE_EN] || !ctrl0_q[cvdsq_pkg::B_ON]) begin
      second_q <= 1'b0;
    end else if (end_conv) begin
      second_q <= !second_q;
    end
  end

  // an abort stores the partial value but raises neither flag nor pulse
  // results, flags and compute strobe
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      res_q <= 16'h0000;
      prev_q <= 16'h0000;
      cif_q <= 1'b0;
      tif_q <= 1'b0;
      compute_pulse <= 1'b0;
    end else begin
      compute_pulse <= 1'b0;
      // flag clears by writing one; a same-cycle set wins
      if (wr_pend_q && widx_q == cvdsq_pkg::IDX_STAT && hwdata[cvdsq_pkg::B_CIF]) begin
        cif_q <= 1'b0;
      end
      if (wr_pend_q && widx_q == cvdsq_pkg::IDX_STAT && hwdata[cvdsq_pkg::B_TIF]) begin
        tif_q <= 1'b0;
      end
      if (sw_go_clr && st_q != cvdsq_pkg::CVDSQ_IDLE) begin
        res_q <= justify(sample_data);
      end else if (end_conv) begin
        prev_q <= res_q;
        res_q <= justify(sample_data);
        if (second_q || !cvdctl_q[cvdsq_pkg::B_DOUBLE_SAMPLE_EN]) begin
          compute_pulse <= 1'b1;
          cif_q <= 1'b1;
          if (threshold_hit) begin
            tif_q <= 1'b1;
          end
        end
      end
    end
  end

  // left justified leaves the low bits zero
  // result placement within 16 bits
  function automatic logic [15:0] justify(input logic [RES_W-1:0] v);
    if (ctrl0_q[cvdsq_pkg::B_FM]) begin
      justify = 16'(v);
    end else begin
      justify = 16'({v, (16 - RES_W)'(0)});
    end
  endfunction

  // registered so that no switch glitches while the state decodes
  // analog switch controls, registered for clean outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_drive_en <= 1'b0;
      pin_drive_level <= 1'b0;
      hold_to_vdd <= 1'b0;
      hold_bias_en <= 1'b0;
      hold_connect <= 1'b0;
      extra_cap_sel <= 8'h00;
    end else begin
      pin_drive_en <= (st_q == cvdsq_pkg::CVDSQ_PRE) && !cvdctl_q[cvdsq_pkg::B_PRECHARGE_INTERNAL_ONLY];
      pin_drive_level <= cvdctl_q[cvdsq_pkg::B_PRECHARGE_POLARITY] ^ (invert_precharge_en_act && second_q);
      hold_to_vdd <= !(cvdctl_q[cvdsq_pkg::B_PRECHARGE_POLARITY] ^ (invert_precharge_en_act && second_q));
      hold_bias_en <= (st_q == cvdsq_pkg::CVDSQ_PRE);
      hold_connect <= (st_q == cvdsq_pkg::CVDSQ_ACQ);
      extra_cap_sel <= (st_q == cvdsq_pkg::CVDSQ_CONV || st_q == cvdsq_pkg::CVDSQ_IDLE)
                       ? 8'h00 : cap_q;
    end
  end

  // guards keep their last level through conversion and idle
  // guard ring outputs follow stage and polarity bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      guard_out_a <= 1'b0;
      guard_out_b <= 1'b0;
    end else if (st_q == cvdsq_pkg::CVDSQ_PRE) begin
      guard_out_a <= cvdctl_q[cvdsq_pkg::B_GUARD_POLARITY] ^ (invert_precharge_en_act && second_q);
      guard_out_b <= cvdctl_q[cvdsq_pkg::B_GUARD_POLARITY] ^ (invert_precharge_en_act && second_q);
    end else if (st_q == cvdsq_pkg::CVDSQ_ACQ) begin
      guard_out_a <= !(cvdctl_q[cvdsq_pkg::B_GUARD_POLARITY] ^ (invert_precharge_en_act && second_q));
    end
  end
endmodule
`default_nettype wire

// ---- cvdsq_chk_sva.sv ----
// Purpose: port-level checks of the cvd sequencer outputs
// Assumes: one clock hclk, async active-low hresetn
// Notes: sees only top-level ports, attached by bind
`timescale 1ns/10ps
`default_nettype none
module cvdsq_chk (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // analog controls
  input wire logic pin_drive_en,
  input wire logic pin_drive_level,
  input wire logic hold_to_vdd,
  input wire logic hold_bias_en,
  input wire logic hold_connect,
  input wire logic [7:0] extra_cap_sel,
  input wire logic guard_out_a,
  input wire logic guard_out_b,
  input wire logic compute_pulse
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // stage boundaries seen at the ports
  sequence s_pre_end; $fell(hold_bias_en); endsequence
  // acquisition straight from idle may leave guard a unchanged, so only precharged starts count
  sequence s_acq_go; hold_bias_en ##1 $rose(hold_connect); endsequence
  property p_no_drive; hold_connect |-> !pin_drive_en && !hold_bias_en; endproperty
  a_no_drive: assert property (p_no_drive) else $error("pin driven in acquisition");
  property p_pin_opp; pin_drive_en |-> hold_bias_en && pin_drive_level != hold_to_vdd; endproperty
  a_pin_opp: assert property (p_pin_opp) else $error("pin and hold not opposite");
  property p_acq_follow; s_pre_end |-> hold_connect; endproperty
  a_acq_follow: assert property (p_acq_follow) else $error("no acquisition after precharge");
  property p_guard_a; s_acq_go |-> guard_out_a != $past(guard_out_a) && $stable(guard_out_b); endproperty
  a_guard_a: assert property (p_guard_a) else $error("guard a did not toggle alone");
  property p_guard_eq; $rose(hold_bias_en) |-> guard_out_a == guard_out_b; endproperty
  a_guard_eq: assert property (p_guard_eq) else $error("guards differ at precharge");
  property p_cap_win; extra_cap_sel != 8'h00 |-> hold_bias_en || hold_connect; endproperty
  a_cap_win: assert property (p_cap_win) else $error("extra cap outside sampling");
  property p_cap_off; $fell(hold_connect) |-> extra_cap_sel == 8'h00; endproperty
  a_cap_off: assert property (p_cap_off) else $error("extra cap kept in conversion");
  // a compute needs eight quiet cycles between pulses, fewer than a whole conversion
  property p_comp; compute_pulse |=> !compute_pulse [*8]; endproperty
  a_comp: assert property (p_comp) else $error("compute pulses too close");
endmodule
bind cvdsq_top cvdsq_chk i_chk (.hclk(hclk), .hresetn(hresetn), .pin_drive_en(pin_drive_en),
  .pin_drive_level(pin_drive_level), .hold_to_vdd(hold_to_vdd), .hold_bias_en(hold_bias_en),
  .hold_connect(hold_connect), .extra_cap_sel(extra_cap_sel), .guard_out_a(guard_out_a),
  .guard_out_b(guard_out_b), .compute_pulse(compute_pulse));
`default_nettype wire

// ---- cvdsq_sensor.sv ----
// Purpose: behavioural sensor electrode and hold charge sharing
// Assumes: equal sensor and hold capacitance
// Notes: result is the mean of the two precharged codes
`timescale 1ns/10ps
`default_nettype none
module cvdsq_sensor (
  // clock
  input wire logic hclk,
  // pin and hold controls
  input wire logic pin_drive_en,
  input wire logic pin_drive_level,
  input wire logic hold_to_vdd,
  input wire logic hold_bias_en,
  input wire logic hold_connect,
  // converter value
  output logic [9:0] sample_data
);
  logic [9:0] node_q = 10'h000; // electrode charge, keeps last level when undriven
  logic [9:0] hold_q = 10'h000; // hold capacitor charge
  logic [9:0] share_q = 10'h000; // settled shared level
  // charge moves only while a path is closed
  always @(posedge hclk) begin
    if (pin_drive_en) node_q <= pin_drive_level ? 10'h3FF : 10'h000;
    if (hold_bias_en) hold_q <= hold_to_vdd ? 10'h3FF : 10'h000;
    if (hold_connect) share_q <= 10'((11'(node_q) + 11'(hold_q)) >> 1);
  end
  assign sample_data = share_q;
endmodule
`default_nettype wire

// ---- test_cvd_adc_sequence_control.sv ----
// Purpose: self-checking bench for cvdsq_top
// Assumes: zero-wait ahb-lite slave, divider reload 0 unless a scenario sets it
// Notes: stage lengths measured on analog control ports
`timescale 1ns/10ps
`default_nettype none
module test_cvd_adc_sequence_control;
  localparam logic [15:0] C0 = cvdsq_pkg::IDX_CTRL0; // short index names
  localparam logic [15:0] C1 = cvdsq_pkg::IDX_CVDCTL;
  logic hclk, hresetn, hsel, hwrite, rc_osc_tick, hreadyout, hresp, threshold_hit;
  logic pin_drive_en, pin_drive_level, hold_to_vdd, hold_bias_en, hold_connect;
  logic guard_out_a, guard_out_b, compute_pulse;
  logic [31:0] haddr, hwdata, hrdata, rdat;
  logic [1:0] htrans, g_pre, g_acq; // guards at stage starts
  logic [2:0] hsize, lvl; // pin en, pin level, hold high
  logic [9:0] sample_data;
  logic [7:0] extra_cap_sel, cap0;
  int bad_count, cmp_count, n_comp, nb, nc, tk, c0;
  cvdsq_top #(.RES_W(10)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rc_osc_tick(rc_osc_tick),
    .sample_data(sample_data), .threshold_hit(threshold_hit), .pin_drive_en(pin_drive_en),
    .pin_drive_level(pin_drive_level), .hold_to_vdd(hold_to_vdd), .hold_bias_en(hold_bias_en),
    .hold_connect(hold_connect), .extra_cap_sel(extra_cap_sel), .guard_out_a(guard_out_a),
    .guard_out_b(guard_out_b), .compute_pulse(compute_pulse));
  cvdsq_sensor i_sensor (.hclk(hclk), .pin_drive_en(pin_drive_en), .pin_drive_level(pin_drive_level),
    .hold_to_vdd(hold_to_vdd), .hold_bias_en(hold_bias_en), .hold_connect(hold_connect),
    .sample_data(sample_data));
  // clock, 100 ns period
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  // oscillator tick every fourth cycle, slower than the divider
  always @(posedge hclk) begin
    tk <= (tk + 1) % 4;
    rc_osc_tick <= (tk == 3);
    if (compute_pulse === 1'b1) n_comp <= n_comp + 1;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one single transfer, entered just after a rising edge
  task automatic bus(input logic w, input logic [15:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {14'h0000, idx, 2'b00};
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 20) begin
      n++;
      @(posedge hclk);
    end
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 40) begin
      n++;
      @(posedge hclk);
    end
    rdat = hrdata;
    check({30'h0, hreadyout, hresp}, 32'h2);
  endtask
  // time the precharge and acquisition stages, bounded wait
  task automatic measure;
    int w;
    w = 0;
    nb = 0;
    nc = 0;
    @(negedge hclk);
    while (hold_bias_en !== 1'b1 && hold_connect !== 1'b1 && w < 100) begin
      w++;
      @(negedge hclk);
    end
    g_pre = {guard_out_a, guard_out_b};
    lvl = {pin_drive_en, pin_drive_level, hold_to_vdd};
    cap0 = extra_cap_sel;
    while (hold_bias_en === 1'b1) begin
      nb++;
      @(negedge hclk);
    end
    g_acq = {guard_out_a, guard_out_b};
    while (hold_connect === 1'b1 && nc < 400) begin
      nc++;
      @(negedge hclk);
    end
    @(posedge hclk);
  endtask
  task automatic start(input logic [7:0] c, input logic [7:0] pre, input logic [7:0] acq,
                       input logic [7:0] g);
    bus(1'b1, C1, {24'h0, c});
    bus(1'b1, cvdsq_pkg::IDX_PRE, {24'h0, pre});
    bus(1'b1, cvdsq_pkg::IDX_ACQ, {24'h0, acq});
    bus(1'b1, C0, {24'h0, g});
    measure;
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    bus(1'b0, C0, 32'h0);
    while (rdat[0] !== 1'b0 && n < 400) begin
      n++;
      bus(1'b0, C0, 32'h0);
    end
    check(32'(n < 400), 32'h1);
  endtask
  // reset values, unmapped place, start without enable
  task automatic t_reset;
    bus(1'b0, C0, 32'h0);
    check(rdat, 32'h0);
    bus(1'b0, C1, 32'h0);
    check(rdat, 32'h0);
    bus(1'b1, 16'h1D30, 32'hFF);
    bus(1'b0, 16'h1D30, 32'h0);
    check(rdat, 32'h0);
    bus(1'b1, C0, 32'h01);
    measure;
    check(32'(nb + nc), 32'h0);
  endtask
  // one conversion, guards high, pin high
  task automatic t_single;
    bus(1'b1, cvdsq_pkg::IDX_CAP, 32'h5A);
    c0 = n_comp;
    start(8'hA0, 8'h02, 8'h03, 8'h85);
    check(32'(nb), 32'h2);
    check(32'(nc), 32'h3);
    check({30'h0, g_pre}, 32'h3);
    check({30'h0, g_acq}, 32'h1);
    check({29'h0, lvl}, 32'h6);
    check({24'h0, cap0}, 32'h5A);
    bus(1'b0, C0, 32'h0);
    check({31'h0, rdat[0]}, 32'h1);
    wait_idle;
    check(32'(n_comp - c0), 32'h1);
    bus(1'b0, cvdsq_pkg::IDX_RES, 32'h0);
    check(rdat, 32'h1FF);
  endtask
  // zero acquisition, internal-only, skipped precharge
  task automatic t_counts;
    start(8'h02, 8'h01, 8'h00, 8'h85);
    check(32'(nc), 32'd256);
    check({31'h0, lvl[2]}, 32'h0);
    wait_idle;
    start(8'h00, 8'h00, 8'h03, 8'h85);
    check(32'(nb * 10 + nc), 32'd3);
    wait_idle;
    start(8'h00, 8'h00, 8'h00, 8'h85);
    check(32'(nb + nc), 32'h0);
    wait_idle;
    start(8'h00, 8'h02, 8'h01, 8'h95);
    check(32'(nb > 4 && nb < 9), 32'h1);
    wait_idle;
    bus(1'b1, cvdsq_pkg::IDX_CLKDIV, 32'h3);
    start(8'h00, 8'h02, 8'h01, 8'h85);
    check(32'(nb > 4 && nb < 9), 32'h1);
    wait_idle;
    bus(1'b1, cvdsq_pkg::IDX_CLKDIV, 32'h0);
  endtask
  // pair with inverted second cycle
  task automatic t_double;
    c0 = n_comp;
    start(8'h61, 8'h01, 8'h01, 8'h85);
    check({28'h0, g_pre, g_acq}, 32'hD);
    wait_idle;
    check(32'(n_comp - c0), 32'h0);
    bus(1'b1, C0, 32'h85);
    measure;
    check({28'h0, g_pre, g_acq}, 32'h2);
    wait_idle;
    check(32'(n_comp - c0), 32'h1);
  endtask
  // continuous retrigger, then software abort in conversion
  task automatic t_continuous_en;
    start(8'h00, 8'h01, 8'h01, 8'hC5);
    measure;
    check(32'(nb), 32'h1);
    c0 = n_comp;
    bus(1'b1, C0, 32'hC4);
    bus(1'b0, C0, 32'h0);
    check({31'h0, rdat[0]}, 32'h0);
    measure;
    check(32'(nb + nc + n_comp - c0), 32'h0);
  endtask
  // stop on threshold ends continuous retrigger after one conversion
  task automatic t_thresh;
    bus(1'b1, cvdsq_pkg::IDX_STAT, 32'h7);
    threshold_hit <= 1'b1;
    c0 = n_comp;
    start(8'h00, 8'h01, 8'h01, 8'hC5);
    wait_idle;
    check(32'(n_comp - c0), 32'h1);
    bus(1'b0, cvdsq_pkg::IDX_STAT, 32'h0);
    check(rdat, 32'h7);
    threshold_hit <= 1'b0;
  endtask
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // watchdog well beyond the expected thousand or so cycles
  initial begin
    #2000000;
    bad_count++;
    give_verdict;
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    rc_osc_tick = 1'b0;
    threshold_hit = 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_single;
    t_counts;
    t_double;
    t_continuous_en;
    t_thresh;
    give_verdict;
  end
endmodule
`default_nettype wire
